// ### hw/wcps_pkg.sv
// Package for the work cycle phase sequencer: phases, timing defaults, carriers
package wcps_pkg;
	// Platform clock period in nanoseconds
	localparam int unsigned CLK_PERIOD_NS = 8;
	// Inter-chassis hop budget in milliseconds
	localparam int unsigned HOP_BUDGET_MS = 5;
	// Hop budget in clock cycles, rounded down
	localparam int unsigned HOP_BUDGET_CYC = (HOP_BUDGET_MS * 1000000) / CLK_PERIOD_NS;
	// Default durations in clock cycles (real values are not published)
	localparam int unsigned INIT_CYC_DEF = 64;
	localparam int unsigned RECV_CYC_DEF = 16;
	localparam int unsigned EVAL_CYC_DEF = 16;
	localparam int unsigned SEND_CYC_DEF = 16;
	localparam int unsigned SWITCH_CYC_DEF = 16;
	// Width of phase timers and length ports
	localparam int unsigned CNT_W = 24;

	// Sequencer states
	typedef enum logic [2:0] {
		WCPS_OFF = 3'b000,
		WCPS_INIT = 3'b001,
		WCPS_RECV = 3'b010,
		WCPS_EVAL = 3'b011,
		WCPS_SEND = 3'b100,
		WCPS_SWITCH = 3'b101
	} wcps_state_t;

	// Per-module phase lengths in clock cycles
	typedef struct packed {
		logic [CNT_W-1:0] recv_len;
		logic [CNT_W-1:0] eval_len;
		logic [CNT_W-1:0] send_len;
		logic [CNT_W-1:0] switch_len;
	} wcps_timing_t;

	// Phase strobes towards the chassis modules
	typedef struct packed {
		logic input_receive_phase;
		logic logic_eval_phase;
		logic output_send_phase;
		logic output_switch_phase;
	} wcps_phase_t;
endpackage

// ### hw/wcps_timer.sv
// Down counter that reports expiry of a loaded duration
`timescale 1ns/1ns
module wcps_timer
	import wcps_pkg::*;
#(
	parameter int unsigned W = CNT_W
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic load_i,
	input wire logic [W-1:0] len_i,
	output logic done_o
);
	// Remaining cycles
	logic [W-1:0] count_reg;

	// Load length minus one so a length of N lasts N cycles; zero counts as one
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			count_reg <= '0;
		end else if (load_i) begin
			count_reg <= (len_i == '0) ? '0 : len_i - W'(1);
		end else if (count_reg != '0) begin
			count_reg <= count_reg - W'(1);
		end
	end

	// Expiry when the count has run out; kept free of load_i so the owner,
	// whose reload depends on this flag, forms no combinational loop
	assign done_o = (count_reg == '0);
endmodule

// ### hw/wcps_sequencer.sv
// Work cycle phase sequencer of the central logic module
`timescale 1ns/1ns
module wcps_sequencer
	import wcps_pkg::*;
#(
	parameter int unsigned INIT_CYC = INIT_CYC_DEF,
	parameter int unsigned NUM_MOD = 5
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic power_good_i,
	input wire logic [$clog2(NUM_MOD)-1:0] module_sel_i,
	input wire wcps_timing_t [NUM_MOD-1:0] timing_i,
	input wire logic remote_valid_i,
	output wcps_phase_t phase_o,
	output logic boot_busy_o,
	output logic self_diag_en_o,
	output logic cycle_start_o,
	output logic remote_take_o,
	output logic link_send_o,
	output logic hop_late_o
);
	// Sequencer state and next value
	wcps_state_t state_reg;
	wcps_state_t state_next;
	// Timer control
	logic load_next;
	logic [CNT_W-1:0] len_next;
	logic timer_done;
	// Timing set of the selected module type
	wcps_timing_t sel_timing;
	// Remote data pending capture at the next receive phase
	logic remote_pend_reg;
	// Hop age counter since the link handed over data
	logic [31:0] hop_age_reg;
	logic hop_arm_reg;
	// Cycles the running boot has lasted, for the boot length check
	logic [CNT_W-1:0] boot_cnt_reg;

	// Select the timing set for the chosen module type
	assign sel_timing = timing_i[module_sel_i];

	// Shared phase timer
	wcps_timer #(
		.W(CNT_W)
	) u_timer (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.load_i(load_next),
		.len_i(len_next),
		.done_o(timer_done)
	);

	// Next state and timer reload
	always_comb begin
		state_next = state_reg;
		load_next = 1'b0;
		len_next = '0;
		case (state_reg)
			WCPS_OFF: begin
				// Leave unpowered mode into initial boot mode
				if (power_good_i) begin
					state_next = WCPS_INIT;
					load_next = 1'b1;
					len_next = CNT_W'(INIT_CYC);
				end
			end
			WCPS_INIT: begin
				if (timer_done) begin
					state_next = WCPS_RECV;
					load_next = 1'b1;
					len_next = sel_timing.recv_len;
				end
			end
			WCPS_RECV: begin
				if (timer_done) begin
					state_next = WCPS_EVAL;
					load_next = 1'b1;
					len_next = sel_timing.eval_len;
				end
			end
			WCPS_EVAL: begin
				if (timer_done) begin
					state_next = WCPS_SEND;
					load_next = 1'b1;
					len_next = sel_timing.send_len;
				end
			end
			WCPS_SEND: begin
				if (timer_done) begin
					state_next = WCPS_SWITCH;
					load_next = 1'b1;
					len_next = sel_timing.switch_len;
				end
			end
			WCPS_SWITCH: begin
				// Back to back cycles without end
				if (timer_done) begin
					state_next = WCPS_RECV;
					load_next = 1'b1;
					len_next = sel_timing.recv_len;
				end
			end
			default: begin
				state_next = WCPS_OFF;
			end
		endcase
	end

	// State register; loss of power returns to unpowered mode
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_reg <= WCPS_OFF;
		end else if (!power_good_i) begin
			state_reg <= WCPS_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// Registered phase strobes, aligned with the next state
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			phase_o <= '0;
			boot_busy_o <= 1'b0;
			cycle_start_o <= 1'b0;
		end else begin
			phase_o.input_receive_phase <= power_good_i && state_next == WCPS_RECV;
			phase_o.logic_eval_phase <= power_good_i && state_next == WCPS_EVAL;
			phase_o.output_send_phase <= power_good_i && state_next == WCPS_SEND;
			phase_o.output_switch_phase <= power_good_i && state_next == WCPS_SWITCH;
			boot_busy_o <= power_good_i && state_next == WCPS_INIT;
			cycle_start_o <= power_good_i && state_next == WCPS_RECV && state_reg != WCPS_RECV;
		end
	end

	// Self-diagnostics run in all cycle phases but evaluation
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			self_diag_en_o <= 1'b0;
		end else begin
			self_diag_en_o <= power_good_i && state_next != WCPS_OFF &&
				state_next != WCPS_INIT && state_next != WCPS_EVAL;
		end
	end

	// Link handshakes: send in send phase, take remote data in receive phase
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			link_send_o <= 1'b0;
			remote_take_o <= 1'b0;
		end else begin
			link_send_o <= power_good_i && state_next == WCPS_SEND;
			// Take pending or arriving data at the first cycle of receive
			remote_take_o <= power_good_i && state_next == WCPS_RECV &&
				state_reg != WCPS_RECV && (remote_pend_reg || remote_valid_i);
		end
	end

	// Remote data pending; arrival wins over the take clearing it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			remote_pend_reg <= 1'b0;
		end else if (remote_valid_i) begin
			remote_pend_reg <= 1'b1;
		end else if (remote_take_o) begin
			remote_pend_reg <= 1'b0;
		end
	end

	// Age of remote data from arrival to its send-out; flags a late hop
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			hop_age_reg <= '0;
			hop_arm_reg <= 1'b0;
			hop_late_o <= 1'b0;
		end else begin
			// New data restarts the age even in the cycle its predecessor is sent
			if (remote_valid_i && (!hop_arm_reg || (state_reg == WCPS_SEND && link_send_o))) begin
				hop_arm_reg <= 1'b1;
				hop_age_reg <= '0;
			end else if (hop_arm_reg && state_reg == WCPS_SEND && link_send_o) begin
				hop_arm_reg <= 1'b0;
			end else if (hop_arm_reg && hop_age_reg != 32'hffffffff) begin
				hop_age_reg <= hop_age_reg + 32'h1;
			end
			hop_late_o <= hop_arm_reg && hop_age_reg >= 32'(HOP_BUDGET_CYC);
		end
	end

	// Boot length counter; restarts whenever boot is not running
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			boot_cnt_reg <= '0;
		end else if (boot_busy_o) begin
			boot_cnt_reg <= boot_cnt_reg + CNT_W'(1);
		end else begin
			boot_cnt_reg <= '0;
		end
	end

	// Evaluation always follows reception
	eval_after_recv_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(state_reg == WCPS_EVAL && $past(state_reg) != WCPS_EVAL) |->
		$past(state_reg) == WCPS_RECV) else $error("eval not after recv");
	// Switch phase is followed by receive
	switch_to_recv_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(state_reg == WCPS_SWITCH && state_next != WCPS_SWITCH && power_good_i) |=>
		state_reg == WCPS_RECV) else $error("cycle did not wrap");
	// Diagnostics off during evaluation
	diag_off_eval_a: assert property (@(posedge clock_i) disable iff (reset_i)
		phase_o.logic_eval_phase |-> !self_diag_en_o) else $error("diag in eval");
	// Diagnostics on during send
	diag_on_send_a: assert property (@(posedge clock_i) disable iff (reset_i)
		phase_o.output_send_phase |-> self_diag_en_o) else $error("diag off in send");
	// One phase at a time
	phase_onehot_a: assert property (@(posedge clock_i) disable iff (reset_i)
		$onehot0(phase_o)) else $error("phases overlap");
	// Link send only in send phase
	link_in_send_a: assert property (@(posedge clock_i) disable iff (reset_i)
		link_send_o |-> phase_o.output_send_phase) else $error("link send misplaced");
	// Remote take only at receive start
	take_in_recv_a: assert property (@(posedge clock_i) disable iff (reset_i)
		remote_take_o |-> phase_o.input_receive_phase && cycle_start_o)
		else $error("remote take misplaced");
	// Remote data present at a receive start is taken
	take_fresh_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(cycle_start_o && $past(remote_pend_reg || remote_valid_i)) |-> remote_take_o)
		else $error("fresh data skipped");
	// A completed boot lasts exactly the configured count, zero counting as one
	init_leads_a: assert property (@(posedge clock_i) disable iff (reset_i)
		($fell(boot_busy_o) && phase_o.input_receive_phase) |->
		boot_cnt_reg == CNT_W'((INIT_CYC == 0) ? 1 : INIT_CYC)) else $error("init length wrong");
endmodule

// ### sim/wcps_link_model.sv
// Behavioural chassis link module facing the sequencer
`timescale 1ns/1ns
module wcps_link_model (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic link_send_i,
	input wire logic [3:0] delay_i,
	output logic remote_valid_o
);
	logic send_reg; // Send level seen at the previous edge
	logic [4:0] wait_reg; // Cycles until remote data arrives, zero when idle
	// Remote data is a one-cycle pulse, late when the delay spans the next cycle start
	assign remote_valid_o = (wait_reg == 5'h1);
	// Take outgoing data at the start of the send phase, answer after the delay
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			send_reg <= 1'b0;
			wait_reg <= 5'h0;
		end else begin
			send_reg <= link_send_i;
			if (link_send_i && !send_reg) begin
				wait_reg <= {1'b0, delay_i};
			end else if (wait_reg != 5'h0) begin
				wait_reg <= wait_reg - 5'h1;
			end
		end
	end
endmodule

// ### sim/tb.sv
// Self-checking testbench for the work cycle phase sequencer
`timescale 1ns/1ns
module tb;
	import wcps_pkg::*;
	localparam int unsigned INIT = 4; // Shortened boot time
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic power_good_i = 1'b0;
	logic [2:0] module_sel_i = 3'h0;
	wcps_timing_t [4:0] timing_i; // Module 0 has a zero switch length
	logic remote_valid_i;
	logic [3:0] link_delay = 4'h1; // Answer delay of the link model
	wcps_phase_t phase_o;
	logic boot_busy_o, self_diag_en_o, cycle_start_o, remote_take_o, link_send_o, hop_late_o;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	wcps_sequencer #(.INIT_CYC(INIT), .NUM_MOD(5)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
		.power_good_i(power_good_i), .module_sel_i(module_sel_i), .timing_i(timing_i),
		.remote_valid_i(remote_valid_i), .phase_o(phase_o), .boot_busy_o(boot_busy_o),
		.self_diag_en_o(self_diag_en_o), .cycle_start_o(cycle_start_o),
		.remote_take_o(remote_take_o), .link_send_o(link_send_o), .hop_late_o(hop_late_o));
	wcps_link_model i_link (.clock_i(clock_i), .reset_i(reset_i), .link_send_i(link_send_o),
		.delay_i(link_delay), .remote_valid_o(remote_valid_i));
	initial forever #4 clock_i = ~clock_i;
	// Distinct lengths per module type
	initial for (int m = 0; m < 5; m++) timing_i[m] <= '{24'(6 + m), 24'h2, 24'h4, 24'(m)};
	// Cut a hang short
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			final_report();
		end
	end
	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic wait_start();
		int n;
		n = 0;
		do begin
			tick();
			n++;
		end while (cycle_start_o !== 1'b1 && n < 200);
		chk(24'(n < 200), 24'h1, "cycle start");
	endtask
	task automatic t_boot();
		int n;
		n = 0;
		@(posedge clock_i) power_good_i <= 1'b1;
		while (boot_busy_o !== 1'b1 && n < 5) begin
			tick();
			n++;
		end
		n = 0;
		while (boot_busy_o === 1'b1 && n < 100) begin
			n++;
			tick();
		end
		chk(24'(n), 24'(INIT), "boot length");
		chk(24'(phase_o), 24'h8, "first phase");
		chk({cycle_start_o, self_diag_en_o}, 24'h3, "start flags");
		$display("test boot done");
	endtask
	task automatic t_phases(input int m);
		int n;
		logic [23:0] len;
		@(posedge clock_i) module_sel_i <= 3'(m);
		wait_start();
		wait_start();
		for (int k = 0; k < 4; k++) begin
			len = 24'(timing_i[m] >> (24 * (3 - k)));
			n = 0;
			while (phase_o === 4'(8 >> k) && n < 100) begin
				chk(24'(self_diag_en_o), 24'(k != 1), "diag");
				chk(24'(link_send_o), 24'(k == 2), "link send");
				n++;
				tick();
			end
			chk(24'(n), (len == 0) ? 24'h1 : len, "phase length");
		end
		chk(24'(cycle_start_o), 24'h1, "next cycle");
		$display("test phases %0d done", m);
	endtask
	task automatic t_remote();
		@(posedge clock_i) module_sel_i <= 3'h0;
		wait_start();
		wait_start();
		chk(24'(remote_take_o), 24'h1, "prompt take");
		link_delay <= 4'h8;
		wait_start();
		chk(24'(remote_take_o), 24'h0, "late data");
		wait_start();
		chk(24'(remote_take_o), 24'h1, "late take");
		chk(24'(hop_late_o), 24'h0, "hop budget");
		$display("test remote done");
	endtask
	task automatic t_power();
		@(posedge clock_i) power_good_i <= 1'b0;
		tick();
		tick();
		tick();
		chk({phase_o, boot_busy_o, self_diag_en_o, link_send_o, cycle_start_o, remote_take_o,
			hop_late_o}, 24'h0, "power off");
		t_boot();
		$display("test power done");
	endtask
	task automatic final_report();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		reset_i <= 1'b0;
		t_boot();
		for (int m = 0; m < 5; m++) t_phases(m);
		t_remote();
		t_power();
		final_report();
	end
endmodule
